/* design/path_pkg.sv */
// Constants, selector codes and register map for the operand and address path
package path_pkg;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int BUS_ADDR_W = 18;
   localparam int SEL_W = 4;
   localparam int TRAP_W = 3;
   localparam int HI_LSB = 8;
   localparam int SIGN_BIT = 7;
   localparam int TRAP_SHIFT = 2;

   localparam logic [1:0] BUS_ADDR_EXT = 2'h0;

   // Constant select codes
   localparam logic [3:0] CS_ZERO = 4'h0;
   localparam logic [3:0] CS_PLUS1 = 4'h1;
   localparam logic [3:0] CS_PLUS2 = 4'h2;
   localparam logic [3:0] CS_MINUS1 = 4'h3;
   localparam logic [3:0] CS_MINUS2 = 4'h4;
   localparam logic [3:0] CS_TRAP_VEC = 4'h5;
   localparam logic [3:0] CS_LOW_MASK = 4'h6;
   localparam logic [3:0] CS_HIGH_MASK = 4'h7;
   localparam logic [3:0] CS_WORD_SIGN = 4'h8;
   localparam logic [3:0] CS_BYTE_SIGN = 4'h9;
   localparam logic [3:0] CS_PLUS4 = 4'hA;
   localparam logic [3:0] CS_TRAP_PSW = 4'hB;

   localparam logic [15:0] K_ZERO = 16'h0000;
   localparam logic [15:0] K_PLUS1 = 16'h0001;
   localparam logic [15:0] K_PLUS2 = 16'h0002;
   localparam logic [15:0] K_PLUS4 = 16'h0004;
   localparam logic [15:0] K_MINUS1 = 16'hFFFF;
   localparam logic [15:0] K_MINUS2 = 16'hFFFE;
   localparam logic [15:0] K_LOW_MASK = 16'h00FF;
   localparam logic [15:0] K_HIGH_MASK = 16'hFF00;
   localparam logic [15:0] K_WORD_SIGN = 16'h8000;
   localparam logic [15:0] K_BYTE_SIGN = 16'h0080;
   localparam logic [15:0] TRAP_VEC_BASE = 16'h0004;

   // Byte source selections of the second ALU input
   typedef enum logic [1:0] {HI_CONST, HI_B_HIGH, HI_B_LOW, HI_SIGN} high_sel_e;
   typedef enum logic [1:0] {LO_CONST, LO_B_LOW, LO_B_HIGH, LO_B_LOW_ALT} low_sel_e;

   // Register port map
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] ADDR_DEC_BASE = 4'h0;
   localparam logic [3:0] ADDR_DEC_MASK = 4'h1;
   localparam logic [3:0] ADDR_B_VIEW = 4'h2;
   localparam logic [3:0] ADDR_BA_VIEW = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;

   localparam logic [15:0] DEC_BASE_RST = 16'hFF00;
   localparam logic [15:0] DEC_MASK_RST = 16'hFF00;
   localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

/* design/constant_generator.sv */
// Combinational constant generator for the second ALU input
`timescale 1ns/10ps
module constant_generator (
   input  wire logic [path_pkg::SEL_W-1:0]  constant_select_field,
   input  wire logic [path_pkg::TRAP_W-1:0] trap_code_input,
   output logic      [path_pkg::WORD_W-1:0] generated_constants
);
   logic [path_pkg::WORD_W-1:0] trap_vec;

   // Vectors sit four bytes apart above the base
   always_comb begin
      trap_vec = path_pkg::TRAP_VEC_BASE
               + (path_pkg::WORD_W'(trap_code_input) << path_pkg::TRAP_SHIFT);
   end

   always_comb begin
      case (constant_select_field)
         path_pkg::CS_ZERO:      generated_constants = path_pkg::K_ZERO;
         path_pkg::CS_PLUS1:     generated_constants = path_pkg::K_PLUS1;
         path_pkg::CS_PLUS2:     generated_constants = path_pkg::K_PLUS2;
         path_pkg::CS_MINUS1:    generated_constants = path_pkg::K_MINUS1;
         path_pkg::CS_MINUS2:    generated_constants = path_pkg::K_MINUS2;
         path_pkg::CS_TRAP_VEC:  generated_constants = trap_vec;
         path_pkg::CS_LOW_MASK:  generated_constants = path_pkg::K_LOW_MASK;
         path_pkg::CS_HIGH_MASK: generated_constants = path_pkg::K_HIGH_MASK;
         path_pkg::CS_WORD_SIGN: generated_constants = path_pkg::K_WORD_SIGN;
         path_pkg::CS_BYTE_SIGN: generated_constants = path_pkg::K_BYTE_SIGN;
         path_pkg::CS_PLUS4:     generated_constants = path_pkg::K_PLUS4;
         path_pkg::CS_TRAP_PSW:  generated_constants = trap_vec + path_pkg::K_PLUS2;
         default:                generated_constants = path_pkg::K_ZERO;
      endcase
   end
endmodule // constant_generator

/* design/operand_two_selector.sv */
// Byte-wise selector feeding the second ALU input
`timescale 1ns/10ps
module operand_two_selector (
   input  wire logic [path_pkg::WORD_W-1:0] generated_constants,
   input  wire logic [path_pkg::WORD_W-1:0] b_word,
   input  path_pkg::high_sel_e              high_sel,
   input  path_pkg::low_sel_e               low_sel,
   output logic      [path_pkg::WORD_W-1:0] selected_word
);
   logic [path_pkg::BYTE_W-1:0] b_high;
   logic [path_pkg::BYTE_W-1:0] b_low;
   logic [path_pkg::BYTE_W-1:0] k_high;
   logic [path_pkg::BYTE_W-1:0] k_low;
   logic [path_pkg::BYTE_W-1:0] out_high;
   logic [path_pkg::BYTE_W-1:0] out_low;

   assign b_high = b_word[path_pkg::HI_LSB +: path_pkg::BYTE_W];
   assign b_low  = b_word[0 +: path_pkg::BYTE_W];
   assign k_high = generated_constants[path_pkg::HI_LSB +: path_pkg::BYTE_W];
   assign k_low  = generated_constants[0 +: path_pkg::BYTE_W];

   // High and low halves decode separately, so swap and sign extend fall out
   always_comb begin
      case (high_sel)
         path_pkg::HI_CONST:  out_high = k_high;
         path_pkg::HI_B_HIGH: out_high = b_high;
         path_pkg::HI_B_LOW:  out_high = b_low;
         path_pkg::HI_SIGN:   out_high = {path_pkg::BYTE_W{b_low[path_pkg::SIGN_BIT]}};
         default:             out_high = k_high;
      endcase
   end

   always_comb begin
      case (low_sel)
         path_pkg::LO_CONST:     out_low = k_low;
         path_pkg::LO_B_LOW:     out_low = b_low;
         path_pkg::LO_B_HIGH:    out_low = b_high;
         path_pkg::LO_B_LOW_ALT: out_low = b_low;
         default:                out_low = k_low;
      endcase
   end

   assign selected_word = {out_high, out_low};
endmodule // operand_two_selector

/* design/operand_address_path.sv */
// Second operand path, B register, address source and bus address register
`timescale 1ns/10ps
module operand_address_path (
   input  wire logic                            mclk,
   input  wire logic                            nrst,
   input  wire logic                            clock_pulse,
   input  wire logic [path_pkg::SEL_W-1:0]      constant_select_field,
   input  wire logic [path_pkg::TRAP_W-1:0]     trap_code_input,
   input  wire logic [1:0]                      high_byte_sel,
   input  wire logic [1:0]                      low_byte_sel,
   input  wire logic                            load_b_en,
   input  wire logic                            load_ba_en,
   input  wire logic                            address_source_alu,
   input  wire logic [path_pkg::WORD_W-1:0]     result_selector,
   input  wire logic [path_pkg::WORD_W-1:0]     read_bus,
   input  wire logic [path_pkg::WORD_W-1:0]     alu_result,
   input  wire logic [path_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [path_pkg::WORD_W-1:0]     reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [path_pkg::WORD_W-1:0]     reg_rdata,
   output logic      [path_pkg::WORD_W-1:0]     alu_second_input,
   output logic      [path_pkg::WORD_W-1:0]     alu_first_input,
   output logic      [path_pkg::BUS_ADDR_W-1:0] bus_address,
   output logic      [path_pkg::WORD_W-1:0]     address_display,
   output logic                                 own_address_hit
);
   typedef struct packed {
      logic [path_pkg::WORD_W-1:0]     b_word;
      logic [path_pkg::WORD_W-1:0]     ba_word;
      logic [path_pkg::WORD_W-1:0]     second_in;
      logic [path_pkg::WORD_W-1:0]     first_in;
      logic [path_pkg::BUS_ADDR_W-1:0] bus_addr;
      logic [path_pkg::WORD_W-1:0]     display;
      logic                            hit;
      logic [path_pkg::WORD_W-1:0]     rdata;
      logic [path_pkg::WORD_W-1:0]     dec_base;
      logic [path_pkg::WORD_W-1:0]     dec_mask;
   } path_s;

   path_s state_reg;
   path_s state_next;

   logic [path_pkg::WORD_W-1:0] constants_word;
   logic [path_pkg::WORD_W-1:0] selected_word;
   logic [path_pkg::WORD_W-1:0] address_source;

   // Decode used for the next-state hit and for the status readback
   function automatic logic addr_match(input logic [path_pkg::WORD_W-1:0] addr,
                                       input logic [path_pkg::WORD_W-1:0] base,
                                       input logic [path_pkg::WORD_W-1:0] mask);
      addr_match = ((addr & mask) == (base & mask));
   endfunction

   constant_generator u_constants (
      .constant_select_field (constant_select_field),
      .trap_code_input       (trap_code_input),
      .generated_constants   (constants_word)
   );

   operand_two_selector u_selector (
      .generated_constants (constants_word),
      .b_word              (state_reg.b_word),
      .high_sel            (path_pkg::high_sel_e'(high_byte_sel)),
      .low_sel             (path_pkg::low_sel_e'(low_byte_sel)),
      .selected_word       (selected_word)
   );

   assign address_source = address_source_alu ? alu_result : read_bus;

   always_comb begin
      state_next = state_reg;
      // B and BA keep their contents unless pulse and enable coincide
      if (clock_pulse && load_b_en) begin
         state_next.b_word = result_selector;
      end
      if (clock_pulse && load_ba_en) begin
         state_next.ba_word = address_source;
      end
      // Outputs are registered, so the ALU sees this cycle's selection one edge later
      state_next.second_in = selected_word;
      state_next.first_in  = read_bus;
      state_next.bus_addr  = {path_pkg::BUS_ADDR_EXT, state_next.ba_word};
      state_next.display   = state_next.ba_word;
      state_next.hit       = addr_match(state_next.ba_word, state_reg.dec_base,
                                        state_reg.dec_mask);
      if (reg_wr) begin
         case (reg_addr)
            path_pkg::ADDR_DEC_BASE: state_next.dec_base = reg_wdata;
            path_pkg::ADDR_DEC_MASK: state_next.dec_mask = reg_wdata;
            default: ;
         endcase
      end
      state_next.rdata = path_pkg::WORD_RST;
      if (reg_rd) begin
         case (reg_addr)
            path_pkg::ADDR_DEC_BASE: state_next.rdata = state_reg.dec_base;
            path_pkg::ADDR_DEC_MASK: state_next.rdata = state_reg.dec_mask;
            path_pkg::ADDR_B_VIEW:   state_next.rdata = state_reg.b_word;
            path_pkg::ADDR_BA_VIEW:  state_next.rdata = state_reg.ba_word;
            path_pkg::ADDR_STATUS:   state_next.rdata = path_pkg::WORD_W'(state_reg.hit);
            default:                 state_next.rdata = path_pkg::WORD_RST;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg.b_word    <= path_pkg::WORD_RST;
         state_reg.ba_word   <= path_pkg::WORD_RST;
         state_reg.second_in <= path_pkg::WORD_RST;
         state_reg.first_in  <= path_pkg::WORD_RST;
         state_reg.bus_addr  <= {path_pkg::BUS_ADDR_EXT, path_pkg::WORD_RST};
         state_reg.display   <= path_pkg::WORD_RST;
         state_reg.hit       <= 1'b0;
         state_reg.rdata     <= path_pkg::WORD_RST;
         state_reg.dec_base  <= path_pkg::DEC_BASE_RST;
         state_reg.dec_mask  <= path_pkg::DEC_MASK_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata        = state_reg.rdata;
   assign alu_second_input = state_reg.second_in;
   assign alu_first_input  = state_reg.first_in;
   assign bus_address      = state_reg.bus_addr;
   assign address_display  = state_reg.display;
   assign own_address_hit  = state_reg.hit;
endmodule // operand_address_path

/* test/path_monitor.sv */
// Port checker for the operand and address path
`timescale 1ns/10ps
module path_monitor (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        clock_pulse,
   input wire logic [3:0]  constant_select_field,
   input wire logic [2:0]  trap_code_input,
   input wire logic [1:0]  high_byte_sel,
   input wire logic [1:0]  low_byte_sel,
   input wire logic        load_b_en,
   input wire logic        load_ba_en,
   input wire logic        address_source_alu,
   input wire logic [15:0] result_selector,
   input wire logic [15:0] read_bus,
   input wire logic [15:0] alu_result,
   input wire logic [15:0] alu_second_input,
   input wire logic [17:0] bus_address,
   input wire logic [15:0] address_display
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Shadow of the B register, which has no port of its own
   logic [15:0] b_reg;
   wire         ld_b = clock_pulse && load_b_en;
   wire         ld_ba = clock_pulse && load_ba_en;
   wire  [15:0] b_swap = {b_reg[7:0], b_reg[15:8]};
   wire  [15:0] b_sext = {{8{b_reg[7]}}, b_reg[7:0]};
   wire  [15:0] trap_vec = path_pkg::TRAP_VEC_BASE + {11'h000, trap_code_input, 2'h0};
   wire         konst = high_byte_sel == 2'h0 && low_byte_sel == 2'h0;
   always_ff @(posedge mclk) begin
      if (!nrst) b_reg <= 16'h0000;
      else if (ld_b) b_reg <= result_selector;
   end
   ba_from_alu_a:
      assert property (ld_ba && address_source_alu |=> address_display == $past(alu_result))
      else $error("address register missed the ALU value");
   ba_from_bus_a:
      assert property (ld_ba && !address_source_alu |=> address_display == $past(read_bus))
      else $error("address register missed the read bus value");
   ba_hold_a:
      assert property (!ld_ba |=> $stable(address_display))
      else $error("address register changed without a load");
   bus_lines_a:
      assert property (bus_address == {2'h0, address_display})
      else $error("bus address lines differ from display");
   const_pick_a:
      assert property (konst && constant_select_field == path_pkg::CS_PLUS1
         |=> alu_second_input == path_pkg::K_PLUS1)
      else $error("increment constant wrong");
   trap_vec_a:
      assert property (konst && constant_select_field == path_pkg::CS_TRAP_VEC
         |=> alu_second_input == $past(trap_vec))
      else $error("trap vector constant wrong");
   sign_fill_a:
      assert property (high_byte_sel == 2'h3 && low_byte_sel == 2'h1
         |=> alu_second_input == $past(b_sext))
      else $error("sign extension wrong");
   swap_bytes_a:
      assert property (high_byte_sel == 2'h2 && low_byte_sel == 2'h2
         |=> alu_second_input == $past(b_swap))
      else $error("byte swap wrong");
   b_direct_a:
      assert property (high_byte_sel == 2'h1 && low_byte_sel == 2'h1
         |=> alu_second_input == $past(b_reg))
      else $error("direct B selection wrong");
   cover property (ld_ba && address_source_alu);
   cover property (high_byte_sel == 2'h3 && low_byte_sel == 2'h1);
   cover property (ld_b ##1 high_byte_sel == 2'h2);
   cover property (konst && constant_select_field == path_pkg::CS_TRAP_VEC);
endmodule // path_monitor

bind operand_address_path path_monitor mon_u (.mclk, .nrst, .clock_pulse,
   .constant_select_field, .trap_code_input, .high_byte_sel, .low_byte_sel, .load_b_en,
   .load_ba_en, .address_source_alu, .result_selector, .read_bus, .alu_result,
   .alu_second_input, .bus_address, .address_display);

/* test/alu_partner.sv */
// ALU stand-in that sums the two registered operand outputs
`timescale 1ns/10ps
module alu_partner (
   input  wire logic [15:0] first_in,
   input  wire logic [15:0] second_in,
   output logic      [15:0] sum
);
   // Adds only; function select lives outside this block
   assign sum = first_in + second_in;
endmodule // alu_partner

/* test/testbench.sv */
// Self-checking bench for the operand and address path
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [1:0]  h;
      logic [1:0]  l;
      logic [3:0]  cs;
      logic [2:0]  tr;
      logic [15:0] ex;
   } row_s;
   logic        mclk = 1'b0, nrst = 1'b0, clock_pulse = 1'b0, load_b_en = 1'b0;
   logic        load_ba_en = 1'b0, address_source_alu = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  constant_select_field = 4'h0, reg_addr = 4'h0;
   logic [2:0]  trap_code_input = 3'h0;
   logic [1:0]  high_byte_sel = 2'h0, low_byte_sel = 2'h0;
   logic [15:0] result_selector = 16'h0000, read_bus = 16'h0000, reg_wdata = 16'h0000;
   logic [15:0] alu_result, reg_rdata, alu_second_input, alu_first_input, address_display;
   logic [17:0] bus_address;
   logic        own_address_hit;
   int          miscompares = 0, checks_done = 0, cycles = 0;
   // B holds 12C5 during these rows; bit 7 set so sign fill shows
   row_s        rows [22] = '{'{2'h0, 2'h0, 4'h1, 3'h0, 16'h0001},
      '{2'h0, 2'h0, 4'h4, 3'h0, 16'hFFFE}, '{2'h0, 2'h0, 4'h5, 3'h3, 16'h0010},
      '{2'h0, 2'h0, 4'h7, 3'h0, 16'hFF00}, '{2'h1, 2'h1, 4'h0, 3'h0, 16'h12C5},
      '{2'h1, 2'h2, 4'h0, 3'h0, 16'h1212}, '{2'h2, 2'h1, 4'h0, 3'h0, 16'hC5C5},
      '{2'h2, 2'h2, 4'h0, 3'h0, 16'hC512}, '{2'h3, 2'h1, 4'h0, 3'h0, 16'hFFC5},
      '{2'h0, 2'h0, 4'h0, 3'h0, 16'h0000}, '{2'h0, 2'h0, 4'h2, 3'h0, 16'h0002},
      '{2'h0, 2'h0, 4'h3, 3'h0, 16'hFFFF}, '{2'h0, 2'h0, 4'h6, 3'h0, 16'h00FF},
      '{2'h0, 2'h0, 4'h8, 3'h0, 16'h8000}, '{2'h0, 2'h0, 4'h9, 3'h0, 16'h0080},
      '{2'h0, 2'h0, 4'hA, 3'h0, 16'h0004}, '{2'h0, 2'h0, 4'hB, 3'h5, 16'h001A},
      '{2'h0, 2'h0, 4'hC, 3'h0, 16'h0000}, '{2'h0, 2'h0, 4'h5, 3'h7, 16'h0020},
      '{2'h0, 2'h3, 4'h7, 3'h0, 16'hFFC5}, '{2'h3, 2'h0, 4'h0, 3'h0, 16'hFF00},
      '{2'h1, 2'h0, 4'h6, 3'h0, 16'h12FF}};
   always #50 mclk = ~mclk;
   operand_address_path dut_u (.mclk, .nrst, .clock_pulse, .constant_select_field,
      .trap_code_input, .high_byte_sel, .low_byte_sel, .load_b_en, .load_ba_en,
      .address_source_alu, .result_selector, .read_bus, .alu_result, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .alu_second_input, .alu_first_input, .bus_address,
      .address_display, .own_address_hit);
   alu_partner alu_u (.first_in(alu_first_input), .second_in(alu_second_input), .sum(alu_result));
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_addr(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input logic lb, lba, cp, src, input logic [15:0] rs, rb);
      @(posedge mclk);
      clock_pulse <= cp;
      load_b_en <= lb;
      load_ba_en <= lba;
      address_source_alu <= src;
      result_selector <= rs;
      read_bus <= rb;
      @(posedge mclk);
      clock_pulse <= 1'b0;
      load_b_en <= 1'b0;
      load_ba_en <= 1'b0;
      #1;
   endtask
   task automatic sel(input row_s r);
      @(posedge mclk);
      high_byte_sel <= r.h;
      low_byte_sel <= r.l;
      constant_select_field <= r.cs;
      trap_code_input <= r.tr;
      @(posedge mclk);
      #1;
   endtask
   task automatic reg_access(input logic wr, input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Whole run needs a few hundred cycles at most after reset
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      pulse(1'b1, 1'b0, 1'b1, 1'b0, 16'h12C5, 16'h0000);
      foreach (rows[i]) begin
         sel(rows[i]);
         chk_word(alu_second_input, rows[i].ex);
      end
      pulse(1'b0, 1'b1, 1'b1, 1'b0, 16'hFFFF, 16'hA5A5);
      chk_addr(bus_address, 18'h0A5A5);
      chk_word(address_display, 16'hA5A5);
      pulse(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h1111);
      pulse(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h2222);
      chk_word(address_display, 16'hA5A5);
      chk_word(alu_first_input, 16'h2222);
      sel(rows[4]);
      chk_word(alu_second_input, 16'h12C5);
      sel(rows[0]);
      pulse(1'b0, 1'b1, 1'b1, 1'b1, 16'h0000, 16'h2222);
      chk_word(address_display, 16'h2223);
      pulse(1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 16'hFF12);
      chk_word({15'h0000, own_address_hit}, 16'h0001);
      reg_access(1'b0, path_pkg::ADDR_BA_VIEW, 16'h0000);
      chk_word(reg_rdata, 16'hFF12);
      reg_access(1'b0, path_pkg::ADDR_STATUS, 16'h0000);
      chk_word(reg_rdata, 16'h0001);
      reg_access(1'b0, path_pkg::ADDR_B_VIEW, 16'h0000);
      chk_word(reg_rdata, 16'h12C5);
      @(posedge mclk);
      #1;
      chk_word(reg_rdata, 16'h0000);
      reg_access(1'b0, path_pkg::ADDR_DEC_MASK, 16'h0000);
      chk_word(reg_rdata, path_pkg::DEC_MASK_RST);
      reg_access(1'b1, 4'hE, 16'h1234);
      reg_access(1'b0, 4'hE, 16'h0000);
      chk_word(reg_rdata, 16'h0000);
      reg_access(1'b1, path_pkg::ADDR_DEC_BASE, 16'h1200);
      repeat (2) @(posedge mclk);
      #1;
      chk_word({15'h0000, own_address_hit}, 16'h0000);
      reg_access(1'b1, path_pkg::ADDR_DEC_MASK, 16'h0000);
      repeat (2) @(posedge mclk);
      #1;
      chk_word({15'h0000, own_address_hit}, 16'h0001);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk_addr(bus_address, 18'h00000);
      chk_word(alu_second_input, 16'h0000);
      chk_word(address_display, 16'h0000);
      @(posedge mclk);
      nrst <= 1'b1;
      sel(rows[4]);
      chk_word(alu_second_input, 16'h0000);
      chk_word({15'h0000, own_address_hit}, 16'h0000);
      reg_access(1'b0, path_pkg::ADDR_DEC_BASE, 16'h0000);
      chk_word(reg_rdata, path_pkg::DEC_BASE_RST);
      results();
   end
endmodule // testbench
